// ---- hw/irss_defs.svh ----
// Purpose: constants of the infrared module serial slave
// Assumes: 100 MHz system clock
// Notes: offsets, codes, reset values and timing counts
`ifndef IRSS_DEFS_SVH
`define IRSS_DEFS_SVH
// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define IRSS_FRAME_BITS 6'd32
`define IRSS_OP_DONE 6'd8
`define IRSS_RD_LOAD 6'd23
`define IRSS_RD_FIRST 6'd24
`define IRSS_CNT_MAX 6'h3f
// ----------------------------------------------------------------
// Internal register offsets and keys
// ----------------------------------------------------------------
`define IRSS_REG_OBJ 8'h09
`define IRSS_REG_AMB 8'h0a
`define IRSS_REG_UNLOCK 8'h10
`define IRSS_REG_PUMP 8'h18
`define IRSS_UNLOCK_KEY 16'hb200
`define IRSS_PUMP_KEY 16'h0065
// ----------------------------------------------------------------
// Nonvolatile word map
// ----------------------------------------------------------------
`define IRSS_NV_OBJ_MIN 5'h00
`define IRSS_NV_OBJ_MAX 5'h01
`define IRSS_NV_AMB_MIN 5'h02
`define IRSS_NV_AMB_MAX 5'h03
`define IRSS_NV_REL_THR 5'h04
`define IRSS_NV_REL_HYS 5'h05
`define IRSS_NV_REL_CFG 5'h06
`define IRSS_NV_USER0 5'h18
`define IRSS_NV_MIN_RST 16'h0000
`define IRSS_NV_MAX_RST 16'h0fff
`define IRSS_NV_THR_RST 16'h0800
`define IRSS_NV_HYS_RST 16'h0040
`define IRSS_NV_ERASED 16'h0000
// ----------------------------------------------------------------
// Temperature code and PWM frame, in 50 us ticks
// ----------------------------------------------------------------
`define IRSS_CODE_MAX 12'hfff
`define IRSS_CODE_MIN 12'h000
`define IRSS_CLK_NS 10
`define IRSS_PWM_TICK_NS 50000
`define IRSS_PWM_LEAD 11'd256
`define IRSS_PWM_UNDER 11'd1408
`define IRSS_PWM_OVER 11'd1536
`define IRSS_PWM_FATAL 11'd1664
`endif

// ---- hw/irss_pkg.sv ----
// Purpose: shared types of the infrared module serial slave
// Assumes: nothing
// Notes: constants live in irss_defs.svh
package irss_pkg;
  typedef enum logic [2:0] {
    OP_NONE, OP_REG_WR, OP_REG_RD, OP_NV_WR, OP_NV_ERASE, OP_NV_RD, OP_NV_BULK_WR, OP_NV_BULK_ERASE
  } irss_op_t;
  typedef enum logic {FR_IDLE, FR_SHIFT} irss_frame_t;
endpackage : irss_pkg

// ---- hw/irss_pwm_if.sv ----
// Purpose: carrier between the core and one PWM generator
// Assumes: tick is a one-cycle enable
// Notes: one instance per temperature output
`timescale 1ns/1ns
interface irss_pwm_if;
  logic tick;
  logic [9:0] value;
  logic under;
  logic over;
  logic fatal;
  logic pwm;
  modport src (output tick, value, under, over, fatal, input pwm);
  modport gen (input tick, value, under, over, fatal, output pwm);
endinterface : irss_pwm_if

// ---- hw/irss_sync.sv ----
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk
// Notes: first stage is read only by the second
`timescale 1ns/1ns
module irss_sync #(
  parameter int W = 1
) (
  input wire logic clk, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic [W-1:0] d, // Asynchronous input
  output logic [W-1:0] q // Synchronised output
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : irss_sync

// ---- hw/irss_pwm.sv ----
// Purpose: one 10-bit PWM temperature output
// Assumes: tick pulses once per 50 us
// Notes: value and condition are sampled at frame start
`timescale 1ns/1ns
`include "irss_defs.svh"
module irss_pwm (
  input wire logic clk, // System clock
  input wire logic rst_b, // Async reset, active low
  irss_pwm_if.gen p // Generator side of the output
);
  logic [10:0] cnt_q;
  logic [10:0] high_end_q;
  // ----------------------------------------------------------------
  // Frame counter, 2048 ticks
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else if (p.tick) begin
      cnt_q <= cnt_q + 11'd1;
    end
  end
  // Latched once per frame so a mid-frame update cannot make a glitch pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      high_end_q <= `IRSS_PWM_LEAD;
    end else if (p.tick && cnt_q == '1) begin
      if (p.fatal) begin
        high_end_q <= `IRSS_PWM_FATAL;
      end else if (p.over) begin
        high_end_q <= `IRSS_PWM_OVER;
      end else if (p.under) begin
        high_end_q <= `IRSS_PWM_UNDER;
      end else begin
        high_end_q <= `IRSS_PWM_LEAD + {1'b0, p.value};
      end
    end
  end
  // Moving only on ticks keeps every level a whole number of ticks, first frame too
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      p.pwm <= 1'b0;
    end else if (p.tick) begin
      p.pwm <= cnt_q < high_end_q;
    end
  end
endmodule : irss_pwm

// ---- hw/irss_top.sv ----
// Purpose: serial slave, temperature registers, NVM, relay and PWM of an IR module
// Assumes: 100 MHz clk; serial clock far slower; measurements from same clock domain
// Notes: serial pins are sampled by clk through two flops
// Behaviour
// - Frame spans chip select low, 32 clocks
// - 32 bits MSB first: op, address, data
// - Sample serial input on rising clock edges
// - Write echo delayed eight clocks on output
// - Early chip select rise cancels command
// - Read returns opcode then data, no address
// - Read data valid from 25th rising edge
// - Decode internal register write and read
// - Decode word write, erase and read
// - Decode bulk write and bulk erase
// - Object at 09h, ambient at 0Ah
// - Code 15:4, over, under, fatal, zero
// - Ambient out of range forces code, flag
// - Code linear between calibrated limits
// - Unlock key freezes temperature outputs
// - Pump key enables NVM programming
// - Eight free user NVM words
// - 12-bit relay comparator, inverting default
// - Polarity decides relay state above threshold
// - 10-bit PWM, 50 us tick, 102.4 ms
// - Lead, data, error and trailing slots
// - Duty cycle linear in temperature
// - Special condition duty cycles
`timescale 1ns/1ns
`include "irss_defs.svh"
module irss_top #(
  parameter int NV_WORDS = 32,
  parameter int PWM_TICK_CYC = `IRSS_PWM_TICK_NS / `IRSS_CLK_NS
) (
  input wire logic clk, // System clock, 100 MHz
  input wire logic rst_b, // Async reset, active low
  input wire logic chip_select_n, // Serial chip select pin
  input wire logic serial_clk_pin, // Serial clock pin from master
  input wire logic serial_in_pin, // Serial data in pin
  output logic serial_out_pin, // Serial data out
  output logic serial_out_oe, // High while data out is driven
  input wire logic [15:0] obj_meas, // Object measurement, raw units
  input wire logic [15:0] amb_meas, // Ambient measurement, raw units
  input wire logic nvm_fatal_in, // Uncorrectable NVM error seen
  output logic relay_drive_out, // Relay open-drain data, always low
  output logic relay_drive_oe, // High while relay pulls low
  output logic obj_pwm_out, // Object temperature PWM
  output logic amb_pwm_out // Ambient temperature PWM
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic irss_pkg::irss_op_t decode_op(input logic [7:0] op);
    irss_pkg::irss_op_t r;
    r = irss_pkg::OP_NONE;
    casez (op)
      8'b?101?0??: r = irss_pkg::OP_REG_WR;
      8'b?10010??: r = irss_pkg::OP_REG_RD;
      8'b0001????: r = irss_pkg::OP_NV_WR;
      8'b001?????: r = irss_pkg::OP_NV_ERASE;
      8'b?0001???: r = irss_pkg::OP_NV_RD;
      8'b1001????: r = irss_pkg::OP_NV_BULK_WR;
      8'b101?????: r = irss_pkg::OP_NV_BULK_ERASE;
      default: r = irss_pkg::OP_NONE;
    endcase
    return r;
  endfunction : decode_op

  // Clamps outside the limits; a degenerate span reads as the low end
  function automatic logic [11:0] scale(input logic [15:0] m, input logic [15:0] lo, input logic [15:0] hi);
    logic [27:0] num;
    logic [27:0] q;
    num = '0;
    q = '0;
    if (m <= lo || hi <= lo) begin
      return `IRSS_CODE_MIN;
    end
    if (m >= hi) begin
      return `IRSS_CODE_MAX;
    end
    num = 28'(m - lo) * 28'(`IRSS_CODE_MAX);
    q = num / 28'(hi - lo);
    return q[11:0];
  endfunction : scale

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [2:0] pins_s;
  logic sclk_d1_q;
  logic csn_d1_q;
  irss_sync #(.W(3)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({chip_select_n, serial_clk_pin, serial_in_pin}),
    .q(pins_s)
  );
  wire csn_s = pins_s[2];
  wire sclk_s = pins_s[1];
  wire sdi_s = pins_s[0];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_d1_q <= 1'b0;
      // Same level as the synchroniser's reset, so no false select fall follows reset; the rise seen as csn_s settles high finds the frame idle
      csn_d1_q <= 1'b0;
    end else begin
      sclk_d1_q <= sclk_s;
      csn_d1_q <= csn_s;
    end
  end
  // Relies on the slow serial clock: every level lasts many system cycles
  wire sclk_rise = sclk_s & ~sclk_d1_q & ~csn_s;
  wire sclk_fall = ~sclk_s & sclk_d1_q & ~csn_s;
  wire cs_fall = ~csn_s & csn_d1_q;
  wire cs_rise = csn_s & ~csn_d1_q;

  // ----------------------------------------------------------------
  // Frame receive
  // ----------------------------------------------------------------
  irss_pkg::irss_frame_t frame_q;
  logic [5:0] cnt_q;
  logic [31:0] shift_q;
  irss_pkg::irss_op_t op_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_q <= irss_pkg::FR_IDLE;
    end else if (cs_fall) begin
      frame_q <= irss_pkg::FR_SHIFT;
    end else if (cs_rise) begin
      frame_q <= irss_pkg::FR_IDLE;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      shift_q <= '0;
    end else if (cs_fall) begin
      cnt_q <= '0;
    end else if (sclk_rise && frame_q == irss_pkg::FR_SHIFT) begin
      shift_q <= {shift_q[30:0], sdi_s};
      if (cnt_q != `IRSS_CNT_MAX) begin
        cnt_q <= cnt_q + 6'd1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      op_q <= irss_pkg::OP_NONE;
    end else if (cs_fall) begin
      op_q <= irss_pkg::OP_NONE;
    end else if (cnt_q == `IRSS_OP_DONE && op_q == irss_pkg::OP_NONE) begin
      op_q <= decode_op(shift_q[7:0]);
    end
  end
  wire is_read = op_q == irss_pkg::OP_REG_RD || op_q == irss_pkg::OP_NV_RD;
  // Only a frame of exactly 32 clocks executes; a short one is dropped
  wire exec = cs_rise && frame_q == irss_pkg::FR_SHIFT && cnt_q == `IRSS_FRAME_BITS;
  wire [7:0] cmd_addr = shift_q[23:16];
  wire [15:0] cmd_data = shift_q[15:0];
  wire [4:0] nv_idx = cmd_addr[4:0];
  wire nv_hit = 32'(cmd_addr) < NV_WORDS;

  // ----------------------------------------------------------------
  // Internal registers
  // ----------------------------------------------------------------
  logic [15:0] unlock_q;
  logic [15:0] pump_q;
  logic [15:0] obj_reg_q;
  logic [15:0] amb_reg_q;
  wire unlocked = unlock_q == `IRSS_UNLOCK_KEY;
  wire pump_on = unlocked && pump_q == `IRSS_PUMP_KEY;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      unlock_q <= '0;
      pump_q <= '0;
    end else if (exec && op_q == irss_pkg::OP_REG_WR) begin
      if (cmd_addr == `IRSS_REG_UNLOCK) begin
        unlock_q <= cmd_data;
      end
      if (cmd_addr == `IRSS_REG_PUMP) begin
        pump_q <= cmd_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Nonvolatile words and boot-time shadow
  // ----------------------------------------------------------------
  logic [15:0] nv_q [NV_WORDS];
  logic boot_done_q;
  logic [15:0] obj_min_q;
  logic [15:0] obj_max_q;
  logic [15:0] amb_min_q;
  logic [15:0] amb_max_q;
  logic [11:0] rel_thr_q;
  logic [11:0] rel_hys_q;
  logic rel_noninv_q;
  // User words sit at IRSS_NV_USER0 onward and have no effect on the block
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NV_WORDS; i++) begin
        nv_q[i] <= `IRSS_NV_ERASED;
      end
      nv_q[`IRSS_NV_OBJ_MAX] <= `IRSS_NV_MAX_RST;
      nv_q[`IRSS_NV_AMB_MAX] <= `IRSS_NV_MAX_RST;
      nv_q[`IRSS_NV_REL_THR] <= `IRSS_NV_THR_RST;
      nv_q[`IRSS_NV_REL_HYS] <= `IRSS_NV_HYS_RST;
    end else if (exec && pump_on) begin
      unique case (op_q)
        irss_pkg::OP_NV_WR: begin
          if (nv_hit) begin
            nv_q[nv_idx] <= cmd_data;
          end
        end
        irss_pkg::OP_NV_ERASE: begin
          if (nv_hit) begin
            nv_q[nv_idx] <= `IRSS_NV_ERASED;
          end
        end
        irss_pkg::OP_NV_BULK_WR: begin
          for (int i = 0; i < NV_WORDS; i++) begin
            nv_q[i] <= cmd_data;
          end
        end
        irss_pkg::OP_NV_BULK_ERASE: begin
          for (int i = 0; i < NV_WORDS; i++) begin
            nv_q[i] <= `IRSS_NV_ERASED;
          end
        end
        default: begin
        end
      endcase
    end
  end
  // Settings are copied once after reset, which also reloads the NVM defaults, so reprogrammed words never reach them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      boot_done_q <= 1'b0;
      obj_min_q <= `IRSS_NV_MIN_RST;
      obj_max_q <= `IRSS_NV_MAX_RST;
      amb_min_q <= `IRSS_NV_MIN_RST;
      amb_max_q <= `IRSS_NV_MAX_RST;
      rel_thr_q <= 12'(`IRSS_NV_THR_RST);
      rel_hys_q <= 12'(`IRSS_NV_HYS_RST);
      rel_noninv_q <= 1'b0;
    end else if (!boot_done_q) begin
      boot_done_q <= 1'b1;
      obj_min_q <= nv_q[`IRSS_NV_OBJ_MIN];
      obj_max_q <= nv_q[`IRSS_NV_OBJ_MAX];
      amb_min_q <= nv_q[`IRSS_NV_AMB_MIN];
      amb_max_q <= nv_q[`IRSS_NV_AMB_MAX];
      rel_thr_q <= nv_q[`IRSS_NV_REL_THR][11:0];
      rel_hys_q <= nv_q[`IRSS_NV_REL_HYS][11:0];
      rel_noninv_q <= nv_q[`IRSS_NV_REL_CFG][0];
    end
  end

  // ----------------------------------------------------------------
  // Temperature registers
  // ----------------------------------------------------------------
  wire ambient_over_flag = amb_meas > amb_max_q;
  wire ambient_under_flag = amb_meas < amb_min_q;
  wire amb_bad = ambient_over_flag | ambient_under_flag;
  logic [11:0] temp_code_obj;
  logic [11:0] temp_code_amb;
  always_comb begin
    temp_code_obj = scale(obj_meas, obj_min_q, obj_max_q);
    temp_code_amb = scale(amb_meas, amb_min_q, amb_max_q);
    if (ambient_over_flag) begin
      temp_code_obj = `IRSS_CODE_MAX;
      temp_code_amb = `IRSS_CODE_MAX;
    end else if (ambient_under_flag) begin
      temp_code_obj = `IRSS_CODE_MIN;
      temp_code_amb = `IRSS_CODE_MIN;
    end
  end
  wire [3:0] flags = {ambient_over_flag, ambient_under_flag, nvm_fatal_in, 1'b0};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      obj_reg_q <= '0;
      amb_reg_q <= '0;
    end else if (boot_done_q && !unlocked) begin
      obj_reg_q <= {temp_code_obj, flags};
      amb_reg_q <= {temp_code_amb, flags};
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  logic [15:0] tx_q;
  logic [15:0] rd_word;
  // Address is in shift_q[14:7] in the cycle that takes the 24th rising edge
  wire [7:0] rd_addr = shift_q[14:7];
  always_comb begin
    rd_word = '0;
    if (op_q == irss_pkg::OP_NV_RD) begin
      rd_word = (32'(rd_addr) < NV_WORDS) ? nv_q[rd_addr[4:0]] : '0;
    end else begin
      unique case (rd_addr)
        `IRSS_REG_OBJ: rd_word = obj_reg_q;
        `IRSS_REG_AMB: rd_word = amb_reg_q;
        `IRSS_REG_UNLOCK: rd_word = unlock_q;
        `IRSS_REG_PUMP: rd_word = pump_q;
        default: rd_word = '0;
      endcase
    end
  end
  // Word is taken once, so a register that moves mid-read cannot tear it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_q <= '0;
    end else if (sclk_rise && cnt_q == `IRSS_RD_LOAD) begin
      tx_q <= rd_word;
    end else if (sclk_fall && cnt_q >= `IRSS_RD_FIRST) begin
      tx_q <= {tx_q[14:0], 1'b0};
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_out_pin <= 1'b0;
    end else if (cs_fall) begin
      serial_out_pin <= 1'b0;
    end else if (sclk_fall) begin
      if (is_read && cnt_q >= `IRSS_RD_FIRST) begin
        serial_out_pin <= tx_q[15];
      end else if (is_read && cnt_q > `IRSS_OP_DONE + 6'd7) begin
        serial_out_pin <= 1'b0;
      end else begin
        serial_out_pin <= shift_q[7];
      end
    end
  end
  assign serial_out_oe = frame_q == irss_pkg::FR_SHIFT;

  // ----------------------------------------------------------------
  // Relay comparator
  // ----------------------------------------------------------------
  logic hot_q;
  wire [11:0] relay_code = obj_reg_q[15:4];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hot_q <= 1'b0;
    end else if (relay_code > rel_thr_q) begin
      hot_q <= 1'b1;
    end else if (13'(relay_code) + 13'(rel_hys_q) < 13'(rel_thr_q)) begin
      hot_q <= 1'b0;
    end
  end
  assign relay_drive_out = 1'b0;
  assign relay_drive_oe = rel_noninv_q ? hot_q : ~hot_q;

  // ----------------------------------------------------------------
  // PWM tick and outputs
  // ----------------------------------------------------------------
  logic [15:0] tick_cnt_q;
  logic tick_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_cnt_q == 16'(PWM_TICK_CYC - 1);
      tick_cnt_q <= (tick_cnt_q == 16'(PWM_TICK_CYC - 1)) ? '0 : tick_cnt_q + 16'd1;
    end
  end
  irss_pwm_if obj_if ();
  irss_pwm_if amb_if ();
  assign obj_if.tick = tick_q;
  assign obj_if.value = obj_reg_q[15:6];
  assign obj_if.under = obj_reg_q[2];
  assign obj_if.over = obj_reg_q[3];
  assign obj_if.fatal = obj_reg_q[1];
  assign amb_if.tick = tick_q;
  assign amb_if.value = amb_reg_q[15:6];
  assign amb_if.under = amb_reg_q[2];
  assign amb_if.over = amb_reg_q[3];
  assign amb_if.fatal = amb_reg_q[1];
  irss_pwm u_obj_pwm (
    .clk(clk),
    .rst_b(rst_b),
    .p(obj_if.gen)
  );
  irss_pwm u_amb_pwm (
    .clk(clk),
    .rst_b(rst_b),
    .p(amb_if.gen)
  );
  assign obj_pwm_out = obj_if.pwm;
  assign amb_pwm_out = amb_if.pwm;
endmodule : irss_top

// ---- testbench/irss_top_props.sv ----
// Purpose: pin assertions of the IR serial slave
// Assumes: PWM_TICK_CYC equals the bound design's value
// Notes: bound to irss_top after the module
`timescale 1ns/1ns
module irss_top_props #(
  parameter int PWM_TICK_CYC = 4
) (
  input wire logic clk, // System clock
  input wire logic rst_b, // Async reset
  input wire logic chip_select_n, // Chip select
  input wire logic serial_clk_pin, // Link clock
  input wire logic serial_out_pin, // Data out
  input wire logic serial_out_oe, // Data out enable
  input wire logic relay_drive_out, // Relay data
  input wire logic obj_pwm_out, // Object PWM
  input wire logic amb_pwm_out // Ambient PWM
);
  logic [23:0] ohi_q;
  logic [23:0] olo_q;
  logic [23:0] ahi_q;
  // Run lengths of the PWM levels, in clk cycles
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ohi_q <= '0;
      olo_q <= '0;
      ahi_q <= '0;
    end else begin
      ohi_q <= obj_pwm_out ? ohi_q + 24'h000001 : '0;
      olo_q <= obj_pwm_out ? '0 : olo_q + 24'h000001;
      ahi_q <= amb_pwm_out ? ahi_q + 24'h000001 : '0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_RELAY_LOW: assert property (relay_drive_out == 1'b0)
    else $error("relay data not low");
  AST_OE_IDLE: assert property (chip_select_n [*6] |-> !serial_out_oe)
    else $error("data out driven outside frame");
  AST_OE_FRAME: assert property (!chip_select_n [*6] |-> serial_out_oe)
    else $error("data out not driven in frame");
  AST_SDO_START: assert property ($fell(chip_select_n) && !serial_clk_pin |-> ##6 !serial_out_pin)
    else $error("data out not cleared at frame start");
  AST_SDO_HOLD: assert property ((!chip_select_n && serial_clk_pin) [*6] |-> $stable(serial_out_pin))
    else $error("data out moved while link clock high");
  AST_OBJ_HI_MAX: assert property (ohi_q <= 1664 * PWM_TICK_CYC)
    else $error("object PWM high too long");
  AST_AMB_HI_MAX: assert property (ahi_q <= 1664 * PWM_TICK_CYC)
    else $error("ambient PWM high too long");
  AST_OBJ_LO_MAX: assert property (olo_q <= 1792 * PWM_TICK_CYC)
    else $error("object PWM low too long");
  AST_OBJ_GRAIN: assert property ($fell(obj_pwm_out) |-> ohi_q >= 256 * PWM_TICK_CYC && ohi_q % PWM_TICK_CYC == 0)
    else $error("object PWM high off tick grid");
endmodule : irss_top_props
bind irss_top irss_top_props #(.PWM_TICK_CYC(PWM_TICK_CYC)) u_props (.clk(clk), .rst_b(rst_b),
  .chip_select_n(chip_select_n), .serial_clk_pin(serial_clk_pin), .serial_out_pin(serial_out_pin),
  .serial_out_oe(serial_out_oe), .relay_drive_out(relay_drive_out), .obj_pwm_out(obj_pwm_out),
  .amb_pwm_out(amb_pwm_out));

// ---- testbench/irss_master_model.sv ----
// Purpose: serial master in place of the host controller
// Assumes: link clock 125 ns, low between frames
// Notes: keeps the last 32 bits seen on data out at rising edges
`timescale 1ns/1ns
module irss_master_model (
  input wire logic clk, // System clock
  input wire logic serial_out_pin, // Device data out
  output logic chip_select_n, // Chip select
  output logic serial_clk_pin, // Link clock
  output logic serial_in_pin, // Data to device
  output logic done, // Pulse after a frame
  output logic [31:0] rx_q // Captured bits
);
  initial begin
    chip_select_n = 1'b1;
    serial_clk_pin = 1'b0;
    serial_in_pin = 1'b0;
    done = 1'b0;
    rx_q = 32'h00000000;
  end
  // Fewer than 32 clocks cancels; past 32 the data line toggles
  task frame(input logic [31:0] w, input int n);
    chip_select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      serial_in_pin = (i < 32) ? w[31 - i] : ~serial_in_pin;
      #63 rx_q = {rx_q[30:0], serial_out_pin};
      serial_clk_pin = 1'b1;
      #62 serial_clk_pin = 1'b0; // Short period keeps runs brief; each level still spans many clk
    end
    #63 chip_select_n = 1'b1;
    @(posedge clk) done <= 1'b1;
    @(posedge clk) done <= 1'b0;
    repeat (20) @(posedge clk);
  endtask : frame
endmodule : irss_master_model

// ---- testbench/tb.sv ----
// Purpose: self-checking bench of the IR serial slave
// Assumes: PWM tick shortened to 4 clk
// Notes: frame results are queued by the driver, compared by the monitor
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic fatal = 1'b0;
  logic cs_n, sclk, sdi, sdo, sdo_oe, rel_out, rel_oe, o_pwm, a_pwm, m_done;
  logic [15:0] obj = 16'h0000;
  logic [15:0] amb = 16'h0800;
  logic [15:0] seed = 16'h7f53;
  logic [15:0] v;
  logic [31:0] m_rx;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  initial forever #5 clk = ~clk;
  irss_top #(.PWM_TICK_CYC(4)) u_dut (.clk(clk), .rst_b(rst_b), .chip_select_n(cs_n), .serial_clk_pin(sclk),
    .serial_in_pin(sdi), .serial_out_pin(sdo), .serial_out_oe(sdo_oe), .obj_meas(obj), .amb_meas(amb),
    .nvm_fatal_in(fatal), .relay_drive_out(rel_out), .relay_drive_oe(rel_oe), .obj_pwm_out(o_pwm),
    .amb_pwm_out(a_pwm));
  irss_master_model u_m (.clk(clk), .serial_out_pin(sdo), .chip_select_n(cs_n), .serial_clk_pin(sclk),
    .serial_in_pin(sdi), .done(m_done), .rx_q(m_rx));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task finish_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  task xfer(input logic [31:0] w, input int n, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    u_m.frame(w, n);
  endtask : xfer
  // Reads run 40 clocks so the whole word arrives
  task rd(input logic [7:0] op, input logic [7:0] a, input logic [15:0] d);
    xfer({op, a, 16'h0000}, 40, {op, 8'h00, d}, 32'hffffffff);
  endtask : rd
  task wr(input logic [7:0] op, input logic [7:0] a, input logic [15:0] d);
    xfer({op, a, d}, 32, {8'h00, op, a, d[15:8]}, 32'h00ffffff);
  endtask : wr
  // Skips one frame start so the new value is latched
  task pwm_high(input logic [31:0] e);
    logic [31:0] n;
    n = 32'h00000000;
    @(posedge o_pwm);
    @(posedge o_pwm);
    @(negedge clk);
    while (o_pwm === 1'b1) begin
      n++;
      @(negedge clk);
    end
    check("obj_pwm_high", n, e);
  endtask : pwm_high
  always @(posedge clk) begin
    if (m_done === 1'b1) begin
      check("sdo_word", m_rx & msk_q[0], exp_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    seed = lfsr(seed);
    v = {4'h0, seed[11:0]};
    @(posedge clk) obj <= v;
    repeat (10) @(posedge clk);
    wr(8'h10, 8'h19, 16'hbeef);
    rd(8'h48, 8'h09, {v[11:0], 4'h0});
    rd(8'hcb, 8'h0a, 16'h8000);
    @(posedge clk) amb <= 16'h1000;
    repeat (10) @(posedge clk);
    rd(8'h48, 8'h09, 16'hfff8);
    pwm_high(32'h00001800);
    @(posedge clk) begin
      amb <= 16'h0800;
      fatal <= 1'b1;
    end
    repeat (10) @(posedge clk);
    rd(8'h48, 8'h0a, 16'h8002);
    @(posedge clk) begin
      fatal <= 1'b0;
      obj <= 16'h0900;
    end
    pwm_high(32'h00000d00);
    check("relay_oe", {31'h0, rel_oe}, 32'h0);
    @(posedge clk) obj <= 16'h07d0;
    repeat (20) @(posedge clk);
    check("relay_oe", {31'h0, rel_oe}, 32'h0);
    @(posedge clk) obj <= 16'h0100;
    repeat (20) @(posedge clk);
    check("relay_oe", {31'h0, rel_oe}, 32'h1);
    xfer(32'h5010b200, 24, 32'h00005010, 32'h0000ffff);
    rd(8'h48, 8'h10, 16'h0000);
    wr(8'h50, 8'h10, 16'hb200);
    rd(8'h48, 8'h10, 16'hb200);
    @(posedge clk) obj <= 16'h0321;
    repeat (10) @(posedge clk);
    rd(8'h48, 8'h09, 16'h1000);
    wr(8'hd8, 8'h18, 16'h0065);
    rd(8'h48, 8'h18, 16'h0065);
    seed = lfsr(seed);
    wr(8'h10, 8'h18, seed);
    rd(8'h8f, 8'h18, seed);
    wr(8'h20, 8'h18, 16'h0000);
    rd(8'h08, 8'h18, 16'h0000);
    wr(8'h3f, 8'h1f, 16'h0000);
    wr(8'h1f, 8'h1f, ~seed);
    rd(8'h08, 8'h1f, ~seed);
    rd(8'h08, 8'h19, 16'h0000);
    finish_test();
  end
endmodule : tb
